// ==== hdl/baf_arbiter.sv ====
// bus arbitration unit and fault termination control of the processor
// assumes termination pins change on the falling clock edge; request pins are asynchronous
//
// What this block does
// - request and acknowledge pass a two-stage synchroniser adding up to two cycles
// - sampled on a falling edge, valid internally after the next falling edge
// - one machine; two-wire mode forces acknowledge negated, giving request/grant only
// - machine reads synced request and acknowledge, drives grant and three-state control
// - machine steps on the first rising edge after synced input is valid
// - request during S0 before strobe delays grant to second rising edge
// - machine holds its state during bus states S0 and S1
// - fault recognised when fault asserted with acknowledge and stop negated
// - late fault option: fault within one cycle of acknowledge, stop negated
// - faulted cycle ends in S9, or S21 for read-modify-write write part
// - address and data float while fault stays asserted after termination
// - fault released: stack status, two program counter words, error information
// - then fetch vector entry 2 into program counter and resume
// - late fault option stacks format word and 22 internal state words
// - fault together with stop request starts a retry instead
// - late fault together with stop request also retries
// - retry floats buses until fault and stop are both negated, then reruns same cycle
// - read-modify-write cycles never retry; fault always takes exception
// - bus is released only after the current cycle completes
// - pending request after acknowledge gets grant again with no own cycles
`include "baf_map.svh"

module baf_arbiter #(
    parameter int ERR_WORDS = `BAF_ERR_WORDS
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // arbitration pins
    input wire logic bus_request_n,
    input wire logic grant_acknowledge_n,
    output logic bus_grant_n,
    // mode straps
    input wire logic two_wire_mode,
    input wire logic late_fault_en,
    // processor bus sequencer
    input wire logic cycle_active,
    input wire logic [4:0] bus_state,
    input wire logic cycle_rmw,
    input wire logic rmw_write_part,
    input wire logic address_strobe_n,
    // termination pins
    input wire logic transfer_acknowledge_n,
    input wire logic bus_fault_n,
    input wire logic stop_request_n,
    // bus drive control to the sequencer
    output logic bus_float,
    output logic own_cycle_block,
    output logic cycle_abort,
    output logic retry_go,
    // fault exception sequence
    output logic stack_push,
    output logic [4:0] stack_word,
    output logic vector_fetch,
    output logic [11:0] vector_offset,
    input wire logic vector_valid,
    input wire logic [31:0] vector_data,
    output logic pc_load,
    output logic [31:0] pc_value
);

    // falling-edge synchroniser stages
    logic req_meta_r, req_sync_r, ack_meta_r, ack_sync_r;
    logic r_in, a_in;
    // arbitration state
    baf_pkg::baf_arb_type arb_r, arb_nxt;
    logic g_nxt, t_nxt, hold_arb;
    logic g_dly_r, special_r, req_sync_d_r;
    // fault state
    baf_pkg::baf_flt_type flt_r, flt_nxt;
    logic retry_r, fault_act, stop_act, dtk_act, fault_hit, retry_hit;
    logic [4:0] term_r, word_cnt_r, word_total;

    // sample on falling edges; second stage is the internal value
    always_ff @(negedge clk or posedge rst) begin
        if (rst) begin
            req_meta_r <= 1'b0;
            req_sync_r <= 1'b0;
            ack_meta_r <= 1'b0;
            ack_sync_r <= 1'b0;
        end else if (ce) begin
            req_meta_r <= ~bus_request_n;
            req_sync_r <= req_meta_r;
            ack_meta_r <= ~grant_acknowledge_n;
            ack_sync_r <= ack_meta_r;
        end
    end

    // two-wire mode keeps acknowledge negated inside
    assign r_in = req_sync_r;
    assign a_in = ack_sync_r & ~two_wire_mode;
    assign hold_arb = cycle_active && (bus_state == `BAF_S0 || bus_state == `BAF_S1);

    // arbitration next state
    always_comb begin
        arb_nxt = arb_r;
        if (!hold_arb) begin
            case (arb_r)
                baf_pkg::ARB_OWN: begin
                    if (r_in) arb_nxt = baf_pkg::ARB_GRANT;
                end
                baf_pkg::ARB_GRANT: begin
                    if (a_in) arb_nxt = baf_pkg::ARB_ACKED;
                    else if (!r_in) arb_nxt = baf_pkg::ARB_OWN;
                end
                baf_pkg::ARB_ACKED: begin
                    if (r_in) arb_nxt = baf_pkg::ARB_REGRANT;
                    else if (!a_in) arb_nxt = baf_pkg::ARB_OWN;
                end
                baf_pkg::ARB_REGRANT: begin
                    if (!a_in) arb_nxt = r_in ? baf_pkg::ARB_WAIT : baf_pkg::ARB_OWN;
                end
                baf_pkg::ARB_WAIT: begin
                    if (a_in) arb_nxt = baf_pkg::ARB_ACKED;
                    else if (!r_in) arb_nxt = baf_pkg::ARB_OWN;
                end
                default: arb_nxt = baf_pkg::ARB_OWN;
            endcase
        end
    end

    // grant and three-state control from the next state
    assign g_nxt = arb_nxt inside {baf_pkg::ARB_GRANT, baf_pkg::ARB_REGRANT, baf_pkg::ARB_WAIT};
    assign t_nxt = (arb_nxt inside {baf_pkg::ARB_ACKED, baf_pkg::ARB_REGRANT, baf_pkg::ARB_WAIT})
        || (arb_nxt == baf_pkg::ARB_GRANT && two_wire_mode);

    // arbitration state register, steps on the rising edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) arb_r <= baf_pkg::ARB_OWN;
        else if (ce) arb_r <= arb_nxt;
    end

    // request landing in S0 before the strobe delays grant one more edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            special_r <= 1'b0;
            g_dly_r <= 1'b0;
            req_sync_d_r <= 1'b0;
        end else if (ce) begin
            req_sync_d_r <= r_in;
            g_dly_r <= g_nxt;
            if (!g_nxt && !hold_arb) special_r <= 1'b0; // S0 and S1 keep the mark
            if (r_in && !req_sync_d_r && cycle_active && bus_state == `BAF_S0
                && address_strobe_n) special_r <= 1'b1;
        end
    end

    // grant pin and bus float, registered
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_grant_n <= 1'b1;
            bus_float <= 1'b0;
            own_cycle_block <= 1'b0;
        end else if (ce) begin
            bus_grant_n <= ~(g_nxt && (!special_r || g_dly_r));
            bus_float <= (t_nxt && address_strobe_n)
                || flt_nxt == baf_pkg::FLT_HOLD;
            own_cycle_block <= t_nxt;
        end
    end

    // termination pin decode
    assign fault_act = ~bus_fault_n;
    assign stop_act = ~stop_request_n;
    assign dtk_act = ~transfer_acknowledge_n;
    // normal fault has acknowledge negated; late option accepts it with acknowledge
    assign fault_hit = cycle_active && fault_act && !stop_act
        && (!dtk_act || late_fault_en);
    assign retry_hit = cycle_active && fault_act && stop_act
        && (!dtk_act || late_fault_en) && !cycle_rmw;
    assign word_total = `BAF_BASE_WORDS
        + (late_fault_en ? `BAF_LATE_WORDS : 5'(ERR_WORDS));

    // fault next state
    always_comb begin
        flt_nxt = flt_r;
        case (flt_r)
            baf_pkg::FLT_IDLE: begin
                if (fault_hit || (cycle_active && fault_act && (!dtk_act || late_fault_en)))
                    flt_nxt = baf_pkg::FLT_PEND;
            end
            baf_pkg::FLT_PEND: begin
                if (bus_state == term_r) flt_nxt = baf_pkg::FLT_HOLD;
            end
            baf_pkg::FLT_HOLD: begin
                if (retry_r) begin
                    if (!fault_act && !stop_act) flt_nxt = baf_pkg::FLT_IDLE;
                end else if (!fault_act) begin
                    flt_nxt = baf_pkg::FLT_STACK;
                end
            end
            baf_pkg::FLT_STACK: begin
                if (word_cnt_r == word_total - 5'h01) flt_nxt = baf_pkg::FLT_VEC;
            end
            baf_pkg::FLT_VEC: begin
                if (vector_valid) flt_nxt = baf_pkg::FLT_IDLE;
            end
            default: flt_nxt = baf_pkg::FLT_IDLE;
        endcase
    end

    // fault state and the kind of termination taken
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flt_r <= baf_pkg::FLT_IDLE;
            retry_r <= 1'b0;
            term_r <= `BAF_S_END_RW;
        end else if (ce) begin
            flt_r <= flt_nxt;
            if (flt_r == baf_pkg::FLT_IDLE && flt_nxt == baf_pkg::FLT_PEND) begin
                retry_r <= retry_hit;
                term_r <= rmw_write_part ? `BAF_S_END_RMW_WR : `BAF_S_END_RW;
            end else if (flt_nxt == baf_pkg::FLT_IDLE) begin
                retry_r <= 1'b0; // a finished sequence forgets its retry mark
            end
        end
    end

    // cycle termination and retry strobes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cycle_abort <= 1'b0;
            retry_go <= 1'b0;
        end else if (ce) begin
            cycle_abort <= flt_r == baf_pkg::FLT_PEND && flt_nxt == baf_pkg::FLT_HOLD;
            retry_go <= flt_r == baf_pkg::FLT_HOLD && flt_nxt == baf_pkg::FLT_IDLE;
        end
    end

    // stacking words: 0 status, 1-2 program counter, then error information
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            word_cnt_r <= 5'h00;
            stack_push <= 1'b0;
            stack_word <= 5'h00;
        end else if (ce) begin
            stack_push <= flt_r == baf_pkg::FLT_STACK;
            stack_word <= word_cnt_r;
            if (flt_r == baf_pkg::FLT_STACK) word_cnt_r <= word_cnt_r + 5'h01;
            else word_cnt_r <= 5'h00;
        end
    end

    // vector fetch and program counter load
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vector_fetch <= 1'b0;
            vector_offset <= `BAF_VEC_OFFSET;
            pc_load <= 1'b0;
            pc_value <= 32'h0000_0000;
        end else if (ce) begin
            vector_fetch <= flt_nxt == baf_pkg::FLT_VEC && !vector_valid;
            vector_offset <= 12'({`BAF_VEC_FAULT, 2'b00});
            pc_load <= flt_r == baf_pkg::FLT_VEC && vector_valid;
            if (flt_r == baf_pkg::FLT_VEC && vector_valid) pc_value <= vector_data;
        end
    end

    // checks
    chk_hold_early_states: assert property (@(posedge clk) disable iff (rst)
        (ce && hold_arb) |=> arb_r == $past(arb_r))
        else $error("arbitration moved during S0 or S1");
    chk_idle_no_grant: assert property (@(posedge clk) disable iff (rst)
        (arb_r == baf_pkg::ARB_OWN) |-> bus_grant_n && !own_cycle_block)
        else $error("grant shown while processor owns bus");
    chk_float_on_ack: assert property (@(posedge clk) disable iff (rst)
        (ce && arb_nxt == baf_pkg::ARB_ACKED && address_strobe_n) |=> bus_float)
        else $error("bus not floated after acknowledge");
    chk_two_wire_ack: assert property (@(posedge clk) disable iff (rst)
        (ce && two_wire_mode && arb_r == baf_pkg::ARB_GRANT) |=> arb_r != baf_pkg::ARB_ACKED)
        else $error("acknowledge honoured in two-wire mode");
    chk_fault_end_state: assert property (@(posedge clk) disable iff (rst)
        (ce && flt_r == baf_pkg::FLT_PEND && bus_state == term_r) |=> cycle_abort)
        else $error("faulted cycle not ended in its end state");
    chk_rmw_no_retry: assert property (@(posedge clk) disable iff (rst)
        (ce && flt_r == baf_pkg::FLT_IDLE && cycle_active && cycle_rmw && fault_act)
        |=> !retry_r)
        else $error("read-modify-write cycle set up for retry");
    chk_hold_float: assert property (@(posedge clk) disable iff (rst)
        (ce && flt_r == baf_pkg::FLT_HOLD && fault_act) |=> bus_float)
        else $error("buses driven while fault held");
    chk_retry_release: assert property (@(posedge clk) disable iff (rst)
        retry_go |-> $past(stop_request_n) && $past(retry_r))
        else $error("retry started with stop still asserted");
    chk_stack_length: assert property (@(posedge clk) disable iff (rst)
        (ce && flt_r == baf_pkg::FLT_STACK && flt_nxt == baf_pkg::FLT_VEC)
        |=> stack_push && stack_word == word_total - 5'h01)
        else $error("wrong number of stacked words");
    chk_vector_load: assert property (@(posedge clk) disable iff (rst)
        pc_load |-> pc_value == $past(vector_data) && vector_offset == `BAF_VEC_OFFSET)
        else $error("program counter not loaded from fault vector");
    chk_fault_recog: assert property (@(posedge clk) disable iff (rst)
        (ce && flt_r == baf_pkg::FLT_IDLE && fault_hit)
        |=> flt_r == baf_pkg::FLT_PEND && !retry_r)
        else $error("fault not recognised");
    // synchroniser, grant timing and fault sequence
    chk_sync_two_falls: assert property (@(negedge clk) disable iff (rst)
        ($past(ce) && $past(ce, 2))
        |-> {req_sync_r, ack_sync_r} == ~{$past(bus_request_n, 2), $past(grant_acknowledge_n, 2)})
        else $error("synchronised input late");
    chk_grant_first_rise: assert property (@(posedge clk) disable iff (rst)
        (ce && !hold_arb && arb_r == baf_pkg::ARB_OWN && r_in && !special_r)
        |=> !bus_grant_n)
        else $error("grant not on first rising edge");
    chk_special_delay: assert property (@(posedge clk) disable iff (rst)
        (ce && special_r && arb_r == baf_pkg::ARB_OWN && arb_nxt == baf_pkg::ARB_GRANT)
        |=> bus_grant_n)
        else $error("grant not held back after request in S0");
    chk_regrant_own: assert property (@(posedge clk) disable iff (rst)
        (ce && !hold_arb && !special_r && arb_r == baf_pkg::ARB_ACKED && r_in)
        |=> !bus_grant_n && own_cycle_block)
        else $error("pending request not granted again");
    chk_drop_no_ack: assert property (@(posedge clk) disable iff (rst)
        (ce && !hold_arb && arb_r == baf_pkg::ARB_GRANT && !r_in && !a_in)
        |=> bus_grant_n && !own_cycle_block)
        else $error("bus not kept after unacknowledged request");
    chk_no_float_strobe: assert property (@(posedge clk) disable iff (rst)
        (ce && !address_strobe_n && flt_nxt != baf_pkg::FLT_HOLD) |=> !bus_float)
        else $error("bus floated during own cycle");
    chk_fault_outside: assert property (@(posedge clk) disable iff (rst)
        (ce && flt_r == baf_pkg::FLT_IDLE && !cycle_active) |=> flt_r == baf_pkg::FLT_IDLE)
        else $error("fault taken outside a cycle");
    chk_late_fault: assert property (@(posedge clk) disable iff (rst)
        (ce && flt_r == baf_pkg::FLT_IDLE && late_fault_en && fault_hit && dtk_act)
        |=> flt_r == baf_pkg::FLT_PEND)
        else $error("late fault not recognised");
    chk_retry_start: assert property (@(posedge clk) disable iff (rst)
        (ce && flt_r == baf_pkg::FLT_IDLE && retry_hit)
        |=> flt_r == baf_pkg::FLT_PEND && retry_r)
        else $error("fault with stop not set up for retry");
    chk_stack_order: assert property (@(posedge clk) disable iff (rst)
        (ce && flt_r == baf_pkg::FLT_STACK && word_cnt_r != 5'h00)
        |=> stack_push && stack_word == $past(stack_word) + 5'h01)
        else $error("stacked words out of order");
    chk_vector_after_stack: assert property (@(posedge clk) disable iff (rst)
        (ce && flt_r == baf_pkg::FLT_STACK && flt_nxt == baf_pkg::FLT_VEC && !vector_valid)
        |=> vector_fetch)
        else $error("vector fetch not started");
    cov_handover: cover property (@(posedge clk) disable iff (rst)
        arb_r == baf_pkg::ARB_GRANT ##[1:20] arb_r == baf_pkg::ARB_ACKED);
    cov_regrant: cover property (@(posedge clk) disable iff (rst)
        arb_r == baf_pkg::ARB_REGRANT ##[1:20] arb_r == baf_pkg::ARB_WAIT);
    cov_retry: cover property (@(posedge clk) disable iff (rst) retry_go);
    cov_exception: cover property (@(posedge clk) disable iff (rst) pc_load);
    cov_special_grant: cover property (@(posedge clk) disable iff (rst)
        special_r && !bus_grant_n);

endmodule : baf_arbiter

// ==== hdl/baf_map.svh ====
// constants for the bus arbitration and fault control block
// assumes bus states are numbered as the processor bus sequencer counts them
`ifndef BAF_MAP_SVH
`define BAF_MAP_SVH

// bus states
`define BAF_S0 5'h00
`define BAF_S1 5'h01
`define BAF_S_END_RW 5'h09
`define BAF_S_END_RMW_WR 5'h15

// fault exception frame
`define BAF_BASE_WORDS 5'h03
`define BAF_LATE_WORDS 5'h17
`define BAF_ERR_WORDS 4
`define BAF_VEC_FAULT 8'h02
`define BAF_VEC_OFFSET 12'h008

`endif

// ==== hdl/baf_pkg.sv ====
// types shared by the bus arbitration and fault control block
// assumes baf_map.svh holds the numeric constants
package baf_pkg;

    // arbitration machine, one-hot
    typedef enum logic [4:0] {
        ARB_OWN = 5'h01,
        ARB_GRANT = 5'h02,
        ARB_ACKED = 5'h04,
        ARB_REGRANT = 5'h08,
        ARB_WAIT = 5'h10
    } baf_arb_type;

    // fault handling machine, one-hot
    typedef enum logic [4:0] {
        FLT_IDLE = 5'h01,
        FLT_PEND = 5'h02,
        FLT_HOLD = 5'h04,
        FLT_STACK = 5'h08,
        FLT_VEC = 5'h10
    } baf_flt_type;

endpackage : baf_pkg

// ==== tb/baf_partner.sv ====
// far-side model: other bus master, slave termination logic and vector memory
// assumes the bench calls its tasks just after a falling clock edge
module baf_partner (
    // clock
    input wire logic clk,
    // arbitration pins
    output logic bus_request_n = 1'b1,
    output logic grant_acknowledge_n = 1'b1,
    // termination pins
    output logic transfer_acknowledge_n = 1'b1,
    output logic bus_fault_n = 1'b1,
    output logic stop_request_n = 1'b1,
    // vector memory
    input wire logic vector_fetch,
    input wire logic [3:0] vec_wait,
    output logic vector_valid = 1'b0,
    output logic [31:0] vector_data = 32'h0
);
    logic late_pend = 1'b0;
    logic stop_pend = 1'b0;
    logic [3:0] vec_cnt = 4'h0;
    logic [31:0] vec_word = 32'h0000_2468;
    logic [31:0] vec_last = 32'h0;

    // vector reply after vec_wait cycles, data bus toggles when not driven
    always @(negedge clk) begin
        vector_valid <= 1'b0;
        vector_data <= ~vector_data;
        if (late_pend) begin
            bus_fault_n <= 1'b0;
            late_pend <= 1'b0;
        end
        if (stop_pend) begin
            stop_request_n <= 1'b1;
            stop_pend <= 1'b0;
        end
        if (vector_fetch && !vector_valid) begin
            vec_cnt <= vec_cnt + 4'h1;
            if (vec_cnt >= vec_wait) begin
                vector_valid <= 1'b1;
                vector_data <= vec_word;
                vec_last <= vec_word;
                vec_word <= $urandom;
                vec_cnt <= 4'h0;
            end
        end
    end

    // request and acknowledge change just after a falling edge
    task arb(input logic r, input logic a);
        @(negedge clk);
        bus_request_n <= r;
        grant_acknowledge_n <= a;
    endtask : arb

    // timeout logic ends an unanswered cycle; late form trails an acknowledge
    task fault_on(input logic stp, input logic late);
        stop_request_n <= !stp;
        if (late) begin
            transfer_acknowledge_n <= 1'b0;
            late_pend <= 1'b1;
        end else begin
            bus_fault_n <= 1'b0;
        end
    endtask : fault_on

    // fault goes away one cycle before stop does
    task fault_off;
        @(negedge clk);
        bus_fault_n <= 1'b1;
        transfer_acknowledge_n <= 1'b1;
        stop_pend <= 1'b1;
    endtask : fault_off
endmodule : baf_partner

// ==== tb/testbench.sv ====
// self-checking bench for the bus arbitration and fault control unit
// assumes baf_partner plays the far side; the bench plays the bus sequencer
`include "baf_map.svh"
`define CHK(a, b, m) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
$display("CHECK FAILED t=%0t %s", $time, m); end end
`define WAITV(s, v) begin n = 0; while ((s) !== (v) && n < 20) begin @(negedge clk); n++; end end

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int ERRW = 5;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic two_wire_mode = 1'b0;
    logic late_fault_en = 1'b0;
    logic cycle_active = 1'b0;
    logic cycle_rmw = 1'b0;
    logic rmw_write_part = 1'b0;
    logic address_strobe_n = 1'b1;
    logic [4:0] bus_state = 5'h00;
    logic [3:0] vec_wait = 4'h2;
    logic [3:0] r;
    logic bus_request_n, grant_acknowledge_n, bus_grant_n, transfer_acknowledge_n;
    logic bus_fault_n, stop_request_n, vector_valid, bus_float, own_cycle_block;
    logic cycle_abort, retry_go, stack_push, vector_fetch, pc_load;
    logic [4:0] stack_word;
    logic [11:0] vector_offset;
    logic [31:0] vector_data, pc_value;
    int num_errors = 0;
    int cmp_count = 0;
    int n;

    // block and far side
    baf_arbiter #(.ERR_WORDS(ERRW)) baf_arbiter_inst (
        .clk, .rst, .ce, .bus_request_n, .grant_acknowledge_n, .bus_grant_n, .two_wire_mode,
        .late_fault_en, .cycle_active, .bus_state, .cycle_rmw, .rmw_write_part,
        .address_strobe_n, .transfer_acknowledge_n, .bus_fault_n, .stop_request_n,
        .bus_float, .own_cycle_block, .cycle_abort, .retry_go, .stack_push, .stack_word,
        .vector_fetch, .vector_offset, .vector_valid, .vector_data, .pc_load, .pc_value);
    baf_partner baf_partner_inst (
        .clk, .bus_request_n, .grant_acknowledge_n, .transfer_acknowledge_n, .bus_fault_n,
        .stop_request_n, .vector_fetch, .vec_wait, .vector_valid, .vector_data);

    // 100 MHz clock
    always #5 clk = ~clk;

    // expected frame length and ending bus state
    function automatic int frame_len(input logic late);
        return late ? 3 + 23 : 3 + ERRW;
    endfunction : frame_len
    function automatic int end_state(input logic wp);
        return wp ? `BAF_S_END_RMW_WR : `BAF_S_END_RW;
    endfunction : end_state

    // verdict and end of run
    task stop_test;
        $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test

    // one faulted bus cycle, then tally what follows
    task automatic fault_case(input logic rmw, input logic wp, input logic stp, input logic late);
        int pushes;
        int loads;
        int retries;
        logic hit;
        logic rty;
        hit = !late || late_fault_en;
        rty = stp && !rmw;
        pushes = 0;
        loads = 0;
        retries = 0;
        cycle_rmw <= rmw;
        rmw_write_part <= wp;
        cycle_active <= 1'b1;
        for (int s = 0; s <= end_state(wp); s++) begin
            @(negedge clk);
            bus_state <= 5'(s);
            address_strobe_n <= (s < 2);
            if (s == 6) baf_partner_inst.fault_on(stp, late);
            `CHK(cycle_abort, 1'b0, "early abort")
        end
        `WAITV(cycle_abort, 1'b1)
        `CHK(n < 4, hit, "abort timing")
        cycle_active <= 1'b0;
        address_strobe_n <= 1'b1;
        repeat (2) begin
            @(negedge clk);
            `CHK(bus_float, hit, "float while fault held")
        end
        vec_wait <= 4'($urandom_range(0, 6));
        baf_partner_inst.fault_off();
        repeat (60) begin
            @(negedge clk);
            if (stack_push === 1'b1) begin
                `CHK(stack_word, 5'(pushes), "stack word order")
                pushes++;
            end
            if (vector_fetch === 1'b1) `CHK(vector_offset, 12'h008, "vector entry")
            retries += int'(retry_go === 1'b1);
            if (pc_load === 1'b1) begin
                loads++;
                `CHK(pc_value, baf_partner_inst.vec_last, "handler address")
            end
        end
        `CHK(pushes, (hit && !rty) ? frame_len(late_fault_en) : 0, "frame length")
        `CHK(retries, int'(hit && rty), "retry count")
        `CHK(loads, int'(hit && !rty), "vector load")
    endtask : fault_case

    // cut a hang short
    initial begin
        #300000;
        num_errors++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        stop_test();
    end

    // main sequence
    initial begin
        void'($urandom(54));
        repeat (4) @(negedge clk);
        rst <= 1'b0;
        @(negedge clk);
        `CHK(bus_grant_n, 1'b1, "grant after reset")
        `CHK(own_cycle_block | bus_float, 1'b0, "bus owned after reset")
        baf_partner_inst.arb(1'b0, 1'b1);
        `WAITV(bus_grant_n, 1'b0)
        `CHK(n, 3, "grant latency")
        baf_partner_inst.arb(1'b1, 1'b0);
        `WAITV(bus_grant_n, 1'b1)
        `CHK(own_cycle_block & bus_float, 1'b1, "bus floated after ack")
        baf_partner_inst.arb(1'b0, 1'b0);
        repeat ($urandom_range(1, 4)) @(negedge clk);
        baf_partner_inst.arb(1'b0, 1'b1);
        `WAITV(bus_grant_n, 1'b0)
        `CHK(n < 5 && own_cycle_block === 1'b1, 1'b1, "regrant")
        baf_partner_inst.arb(1'b1, 1'b1);
        `WAITV(own_cycle_block, 1'b0)
        `CHK(n < 6 && bus_grant_n === 1'b1, 1'b1, "bus kept without ack")
        // request in S1 or S0 must wait; S0 before the strobe costs one more edge
        for (int sp = 0; sp < 2; sp++) begin
            cycle_active <= 1'b1;
            bus_state <= 5'(1 - sp);
            baf_partner_inst.arb(1'b0, 1'b1);
            repeat (5) begin
                @(negedge clk);
                `CHK(bus_grant_n, 1'b1, "grant held in S0 S1")
            end
            bus_state <= 5'h02;
            address_strobe_n <= 1'b0;
            `WAITV(bus_grant_n, 1'b0)
            `CHK(n, 1 + sp, "grant after early states")
            baf_partner_inst.arb(1'b1, 1'b0);
            repeat (4) begin
                @(negedge clk);
                `CHK(bus_float, 1'b0, "no float with strobe low")
            end
            cycle_active <= 1'b0;
            address_strobe_n <= 1'b1;
            `WAITV(bus_float, 1'b1)
            `CHK(n < 4, 1'b1, "float after cycle end")
            baf_partner_inst.arb(1'b1, 1'b1);
            `WAITV(own_cycle_block, 1'b0)
        end
        // two-wire mode ignores the acknowledge pin
        two_wire_mode <= 1'b1;
        for (int a = 0; a < 2; a++) begin
            baf_partner_inst.arb(1'b0, 1'(a));
            `WAITV(bus_grant_n, 1'b0)
            `CHK(n == 3 && own_cycle_block === 1'b1, 1'b1, "two-wire grant")
            baf_partner_inst.arb(1'b1, 1'(a));
            `WAITV(own_cycle_block, 1'b0)
            `CHK(n < 5 && bus_grant_n === 1'b1, 1'b1, "two-wire release")
        end
        baf_partner_inst.arb(1'b1, 1'b1);
        two_wire_mode <= 1'b0;
        // a low enable freezes synchroniser and machine
        ce <= 1'b0;
        baf_partner_inst.arb(1'b0, 1'b1);
        repeat (4) begin
            @(negedge clk);
            `CHK(bus_grant_n, 1'b1, "grant while disabled")
        end
        ce <= 1'b1;
        `WAITV(bus_grant_n, 1'b0)
        `CHK(n, 3, "grant after enable")
        baf_partner_inst.arb(1'b1, 1'b1);
        `WAITV(bus_grant_n, 1'b1)
        `CHK(n < 5 && own_cycle_block === 1'b0, 1'b1, "grant withdrawn")
        // corner faults, then random ones
        fault_case(1'b0, 1'b0, 1'b0, 1'b0);
        fault_case(1'b0, 1'b0, 1'b1, 1'b0);
        fault_case(1'b1, 1'b0, 1'b1, 1'b0);
        fault_case(1'b1, 1'b1, 1'b1, 1'b0);
        fault_case(1'b0, 1'b0, 1'b0, 1'b1);
        late_fault_en = 1'b1;
        fault_case(1'b0, 1'b0, 1'b0, 1'b1);
        fault_case(1'b0, 1'b0, 1'b1, 1'b1);
        repeat (12) begin
            r = 4'($urandom);
            late_fault_en = r[3];
            fault_case(r[0] | r[1], r[1], r[2], 1'($urandom_range(0, 1)));
        end
        stop_test();
    end
endmodule : testbench
